// ===== src/rsw_reset_supervisor_watchdog.sv
/*
 * rsw_reset_supervisor_watchdog: merges the external pin, undervoltage,
 * usb bus reset and watchdog overflow into one internal reset, and holds the
 * watchdog counter, its reload and key registers behind an AHB-Lite slave.
 * assumes all inputs synchronous to hclk; the system oscillator is hclk, so a
 * machine cycle is twelve hclk periods.
 */
// Design decision made here: the AHB-Lite interface to the registers.
module rsw_reset_supervisor_watchdog #(
    parameter int UNDERVOLTAGE_HOLD = rsw_pkg::UNDERVOLTAGE_HOLD_CYCLES,
    parameter int WATCHDOG_PULSE_MC = 1 << rsw_pkg::WATCHDOG_PULSE_LOG2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic usb_se0,
    output logic cpu_reset,
    output logic companion_reset_n
);

    localparam int CW = rsw_pkg::WATCHDOG_COUNT_WIDTH;

    ////////////////////////////////////////////////////////////////////////////
    // whole state of the block in one struct
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [7:0] idx;
        logic [31:0] rdata;
        logic [7:0] power_control;
        logic [7:0] usb_enable;
        logic usb_flag;
        logic [3:0] se0_count;
        logic usb_reset;
        logic [7:0] key;
        logic wdog_en;
        logic [CW-1:0] wdog_count;
        logic [3:0] mc_div;
        logic wdog_reset;
        logic [15:0] wdog_hold;
        logic uv_reset;
        logic [31:0] uv_hold;
        logic [2:0] cause;
        logic int_reset;
    } rsw_state_type;

    rsw_state_type s_q;
    rsw_state_type s_d;

    // word index from a byte address; misaligned or high addresses miss
    function automatic logic [8:0] rsw_word_index(input logic [31:0] a);
        if (a[1:0] != 2'b00 || a[31:10] != 22'h0)
            return 9'h100;
        return {1'b0, a[9:2]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic mc_tick;
        logic [6:0] rv;
        logic any_src;
        logic [8:0] widx;
        widx = rsw_word_index(haddr);
        mc_tick = 1'b0;
        rv = 7'h00;
        any_src = 1'b0;
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        s_d.rd_pend = 1'b0;

        // ahb address phase: capture index; read data formed now for next phase
        if (hsel && hready && htrans[1]) begin
            s_d.idx = widx[7:0];
            s_d.wr_pend = hwrite && !widx[8];
            s_d.rd_pend = !hwrite;
            s_d.rdata = 32'h0;
            if (!widx[8]) begin
                case (widx[7:0])
                    rsw_pkg::WATCHDOG_KEY_IDX: s_d.rdata = {24'h0, s_q.key};
                    rsw_pkg::POWER_CONTROL_IDX: s_d.rdata = {24'h0, s_q.power_control};
                    rsw_pkg::USB_INTERRUPT_ENABLE_IDX: s_d.rdata = {24'h0, s_q.usb_enable};
                    rsw_pkg::USB_INTERRUPT_STATUS_IDX:
                        s_d.rdata = 32'(s_q.usb_flag) << rsw_pkg::USB_BUS_RESET_FLAG_BIT;
                    rsw_pkg::RESET_STATUS_IDX: s_d.rdata = {28'h0, s_q.wdog_en, s_q.cause};
                    rsw_pkg::WATCHDOG_COUNT_IDX: s_d.rdata = 32'(s_q.wdog_count);
                    default: s_d.rdata = 32'h0; // reload reads zero, unmapped reads zero
                endcase
            end
        end

        if (usb_se0) begin
            if (s_q.se0_count != 4'hF)
                s_d.se0_count = s_q.se0_count + 4'h1;
        end else begin
            s_d.se0_count = 4'h0;
        end
        // flag set wins over a clearing write in the same cycle
        if (s_q.se0_count == 4'(rsw_pkg::USB_SE0_MIN_SAMPLES - 1) && usb_se0)
            s_d.usb_reset = 1'b1;
        else if (!usb_se0)
            s_d.usb_reset = 1'b0;

        // ahb data phase writes (word index known from address phase)
        if (s_q.wr_pend) begin
            case (s_q.idx)
                rsw_pkg::POWER_CONTROL_IDX: s_d.power_control = hwdata[7:0];
                rsw_pkg::USB_INTERRUPT_ENABLE_IDX: s_d.usb_enable = hwdata[7:0];
                rsw_pkg::USB_INTERRUPT_STATUS_IDX: begin
                    // write one to clear
                    if (hwdata[rsw_pkg::USB_BUS_RESET_FLAG_BIT])
                        s_d.usb_flag = 1'b0;
                end
                rsw_pkg::WATCHDOG_KEY_IDX: begin
                    s_d.key = hwdata[7:0];
                    s_d.wdog_en = (hwdata[7:0] != rsw_pkg::WATCHDOG_KEY_DISABLE);
                end
                default: s_d.key = s_d.key;
            endcase
        end
        if (s_d.usb_reset && !s_q.usb_reset)
            s_d.usb_flag = 1'b1;

        // machine cycle prescaler, runs in idle too
        if (s_q.mc_div == 4'(rsw_pkg::MACHINE_CYCLE_CYCLES - 1)) begin
            s_d.mc_div = 4'h0;
            mc_tick = 1'b1;
        end else begin
            s_d.mc_div = s_q.mc_div + 4'h1;
        end

        if (s_q.wdog_en && mc_tick && !s_q.wdog_reset) begin
            s_d.wdog_count = s_q.wdog_count + 22'h1;
            if (s_q.wdog_count == {CW{1'b1}}) begin
                s_d.wdog_reset = 1'b1;
                s_d.wdog_hold = 16'h0;
            end
        end
        // reload write loads upper seven bits
        rv = hwdata[6:0];
        if (s_q.wr_pend && s_q.idx == rsw_pkg::WATCHDOG_RELOAD_IDX) begin
            // 7Fh out of range ignored; zero clears all
            if (rv <= rsw_pkg::WATCHDOG_RELOAD_MAX)
                s_d.wdog_count = {rv, 15'h0};
        end

        // watchdog reset pulse length in machine cycles
        if (s_q.wdog_reset && mc_tick) begin
            if (s_q.wdog_hold == 16'(WATCHDOG_PULSE_MC - 1))
                s_d.wdog_reset = 1'b0;
            else
                s_d.wdog_hold = s_q.wdog_hold + 16'h1;
        end

        // undervoltage hold after recovery; always clocked
        // bit 5 of power control disables it
        if (supply_low && !s_q.power_control[rsw_pkg::UNDERVOLTAGE_RESET_DISABLE_BIT]) begin
            s_d.uv_reset = 1'b1;
            s_d.uv_hold = 32'h0;
        end else if (s_q.uv_reset) begin
            if (s_q.uv_hold >= 32'(UNDERVOLTAGE_HOLD - 1))
                s_d.uv_reset = 1'b0;
            else
                s_d.uv_hold = s_q.uv_hold + 32'h1;
        end

        any_src = !ext_reset_n || s_q.uv_reset || s_q.wdog_reset
            || (s_q.usb_reset && s_q.usb_enable[rsw_pkg::USB_BUS_RESET_ENABLE_BIT]);
        s_d.int_reset = any_src;
        if (any_src)
            s_d.cause = {s_q.wdog_reset, s_q.uv_reset, !ext_reset_n};

        // internal reset restores control state, watchdog enabled
        if (s_q.int_reset) begin
            s_d.wdog_en = 1'b1;
            s_d.key = rsw_pkg::WATCHDOG_KEY_RESET;
            s_d.usb_enable = rsw_pkg::USB_INTERRUPT_ENABLE_RESET;
            // the disable bit survives so a disabled monitor stays off
            s_d.power_control = s_q.power_control
                & (8'h1 << rsw_pkg::UNDERVOLTAGE_RESET_DISABLE_BIT);
            if (!s_q.wdog_reset)
                s_d.wdog_count = '0;
            s_d.mc_div = s_d.mc_div;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; power-up leaves undervoltage reset enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.wdog_en <= 1'b1;
            s_q.power_control <= rsw_pkg::POWER_CONTROL_RESET;
            s_q.int_reset <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops; slave is zero wait state, always okay
    // internal reset to cpu and active low to companion
    assign cpu_reset = s_q.int_reset;
    assign companion_reset_n = !s_q.int_reset;
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule

// ===== shared/rsw_pkg.sv
/*
 * rsw_pkg: register map, field positions, reset values and timing constants
 * for the reset supervisor and watchdog.
 * assumes a 100 MHz system clock and an AHB-Lite slave with word registers.
 */
package rsw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register word indices (printed offsets are not all multiples of four,
    // so each printed offset is an index and the byte address is four times it)
    localparam logic [7:0] WATCHDOG_RELOAD_IDX = 8'hA6;
    localparam logic [7:0] WATCHDOG_KEY_IDX = 8'hAE;
    localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
    localparam logic [7:0] USB_INTERRUPT_STATUS_IDX = 8'hB0;
    localparam logic [7:0] USB_INTERRUPT_ENABLE_IDX = 8'hB1;
    localparam logic [7:0] RESET_STATUS_IDX = 8'hB2;
    localparam logic [7:0] WATCHDOG_COUNT_IDX = 8'hB3;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and values
    localparam int UNDERVOLTAGE_RESET_DISABLE_BIT = 5;
    localparam int USB_BUS_RESET_ENABLE_BIT = 6;
    localparam int USB_BUS_RESET_FLAG_BIT = 6;
    localparam logic [7:0] WATCHDOG_KEY_DISABLE = 8'h55;
    localparam logic [6:0] WATCHDOG_RELOAD_MAX = 7'h7E;
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] USB_INTERRUPT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] WATCHDOG_KEY_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PER_MACHINE_CYCLE = 12;
    localparam int MACHINE_CYCLE_CYCLES = OSC_PER_MACHINE_CYCLE;
    localparam int UNDERVOLTAGE_HOLD_MS = 10;
    localparam int UNDERVOLTAGE_HOLD_CYCLES = UNDERVOLTAGE_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WATCHDOG_PULSE_LOG2 = 15;
    localparam int WATCHDOG_COUNT_WIDTH = 22;
    localparam int USB_SE0_MIN_SAMPLES = 4;

    typedef enum logic [1:0] {
        RSW_SRC_NONE,
        RSW_SRC_WATCHDOG,
        RSW_SRC_OTHER
    } rsw_src_type;

endpackage

// ===== tb/rsw_chk.sv
/*
 * rsw_chk: port-level assertions for the reset supervisor and watchdog.
 * assumes it is bound to the top module, hready fed back from hreadyout.
 */
module rsw_chk #(
    parameter int UNDERVOLTAGE_HOLD = 20,
    parameter int WATCHDOG_PULSE_MC = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic cpu_reset,
    input wire logic companion_reset_n
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////
    chk_companion_inverse: assert property (companion_reset_n == !cpu_reset)
        else $error("companion reset is not the inverse of cpu reset");
    chk_pin_asserts: assert property ($fell(ext_reset_n) |=> cpu_reset)
        else $error("pin reset did not assert cpu reset");
    chk_pin_holds: assert property (cpu_reset && !ext_reset_n |=> cpu_reset)
        else $error("cpu reset released while the pin is low");
    chk_release_pin: assert property ($fell(cpu_reset) |-> $past(ext_reset_n))
        else $error("cpu reset fell with the pin low");
    chk_release_supply: assert property ($fell(cpu_reset) |-> !$past(supply_low))
        else $error("cpu reset fell with the supply low");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr == 32'h0000_0300 |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    chk_rdata_stands: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
        else $error("read data changed without a transfer");
endmodule

// ===== tb/rsw_ext_model.sv
/*
 * rsw_ext_model: external reset circuitry, supply monitor and usb line.
 * assumes the caller is just past a rising edge of hclk.
 */
module rsw_ext_model #(
    parameter int PIN_LOW = 30
) (
    input wire logic hclk,
    output logic ext_reset_n,
    output logic supply_low,
    output logic usb_se0
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin low at power-up
    // hold is shortened from the real millisecond to keep runs brief
    initial begin
        ext_reset_n = 1'b0;
        supply_low = 1'b0;
        usb_se0 = 1'b0;
        repeat (PIN_LOW) @(posedge hclk);
        ext_reset_n <= 1'b1;
    end
    // each pulse task drives for n edges, then releases
    task automatic pin(input int n);
        ext_reset_n <= 1'b0;
        repeat (n) @(posedge hclk);
        ext_reset_n <= 1'b1;
    endtask
    task automatic low(input int n);
        supply_low <= 1'b1;
        repeat (n) @(posedge hclk);
        supply_low <= 1'b0;
    endtask
    task automatic se0(input int n);
        usb_se0 <= 1'b1;
        repeat (n) @(posedge hclk);
        usb_se0 <= 1'b0;
    endtask
endmodule

// ===== tb/tb_reset_supervisor_watchdog.sv
/*
 * tb_reset_supervisor_watchdog: register and reset-source tests over ahb-lite.
 * assumes zero wait states are not relied on; watchdog overflow is too long here.
 */
module tb_reset_supervisor_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RLD = 32'h298, KEY = 32'h2B8, PC = 32'h21C;
    localparam logic [31:0] USBS = 32'h2C0, USBE = 32'h2C4, STAT = 32'h2C8;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, cpu_reset, companion_reset_n, ext_reset_n, supply_low, usb_se0;
    int mismatches = 0;
    int tests_run = 0;
    always #5 hclk = ~hclk;
    rsw_ext_model #(.PIN_LOW(30)) ext (.hclk(hclk), .ext_reset_n(ext_reset_n),
        .supply_low(supply_low), .usb_se0(usb_se0));
    rsw_reset_supervisor_watchdog #(.UNDERVOLTAGE_HOLD(20), .WATCHDOG_PULSE_MC(4)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_n(ext_reset_n),
        .supply_low(supply_low), .usb_se0(usb_se0), .cpu_reset(cpu_reset),
        .companion_reset_n(companion_reset_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1 rd = hrdata;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // bounded wait for the internal reset to end, then a settling gap
    task automatic wait_rel();
        for (int i = 0; i < 400 && cpu_reset !== 1'b0; i++) @(posedge hclk);
        #1 check(cpu_reset, 1'b0);
        repeat (2) @(posedge hclk);
    endtask
    task automatic print_verdict();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog against hangs; the tests need well under two thousand cycles
    initial begin
        #60000;
        mismatches++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        wait_rel();
        rdchk(PC, 32'h0);
        xfer(1'b0, STAT, 32'h0); check(rd & 32'h8, 32'h8);
        xfer(1'b1, 32'h300, 32'hFF); rdchk(32'h300, 32'h0);
        xfer(1'b1, KEY, 32'h55); rdchk(KEY, 32'h55);
        xfer(1'b0, STAT, 32'h0); check(rd & 32'h8, 32'h0);
        xfer(1'b1, KEY, 32'hAA); xfer(1'b0, STAT, 32'h0); check(rd & 32'h8, 32'h8);
        // reload writes of 7Eh, 7Fh and zero, each read back through the count register
        xfer(1'b1, RLD, 32'h7E); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd[21:15], 32'h7E);
        check(rd[14:0] < 15'h0010, 1'b1);
        xfer(1'b1, RLD, 32'h7F); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd[21:15], 32'h7E);
        xfer(1'b1, RLD, 32'h0); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd < 32'h10, 1'b1);
        xfer(1'b1, KEY, 32'h55); xfer(1'b1, RLD, 32'h0); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd, 32'h0);
        repeat (40) @(posedge hclk); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd, 32'h0);
        xfer(1'b1, KEY, 32'h00); repeat (40) @(posedge hclk); xfer(1'b0, 32'h2CC, 32'h0);
        check(rd != 32'h0, 1'b1);
        $display("key and register tests done");
        ext.se0(3); rdchk(USBS, 32'h0);
        ext.se0(4); rdchk(USBS, 32'h40);
        xfer(1'b1, USBS, 32'h40); rdchk(USBS, 32'h0); check(cpu_reset, 1'b0);
        xfer(1'b1, USBE, 32'h40); rdchk(USBE, 32'h40);
        ext.se0(5); #1 check(cpu_reset, 1'b1);
        wait_rel(); rdchk(USBE, 32'h0); rdchk(KEY, 32'h0);
        $display("usb reset tests done");
        xfer(1'b1, PC, 32'h20); rdchk(PC, 32'h20);
        ext.low(10); repeat (2) @(posedge hclk); #1 check(cpu_reset, 1'b0);
        xfer(1'b1, PC, 32'h0);
        ext.low(10); #1 check(cpu_reset, 1'b1);
        repeat (15) @(posedge hclk); #1 check(companion_reset_n, 1'b0);
        repeat (10) @(posedge hclk); #1 check(cpu_reset, 1'b0);
        xfer(1'b0, STAT, 32'h0); check(rd & 32'h7, 32'h2);
        $display("undervoltage tests done");
        xfer(1'b1, PC, 32'h20);
        ext.pin(8); #1 check(cpu_reset, 1'b1); check(companion_reset_n, 1'b0);
        wait_rel(); xfer(1'b0, STAT, 32'h0); check(rd & 32'h7, 32'h1);
        rdchk(PC, 32'h20);
        $display("pin reset tests done");
        print_verdict();
    end
endmodule
bind rsw_reset_supervisor_watchdog rsw_chk #(.UNDERVOLTAGE_HOLD(UNDERVOLTAGE_HOLD),
    .WATCHDOG_PULSE_MC(WATCHDOG_PULSE_MC)) chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_n(ext_reset_n),
    .supply_low(supply_low), .cpu_reset(cpu_reset), .companion_reset_n(companion_reset_n));
